// ===== rtl/aso_cfg.svh
// Purpose: Offsets, field positions, reset values and counts of the serial output port
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Definitions only
`ifndef ASO_CFG_SVH
`define ASO_CFG_SVH
`define ASO_CTRL_OFS      12'h000
`define ASO_STATUS_OFS    12'h004
`define ASO_WORD_OFS      12'h008
`define ASO_FRAMES_OFS    12'h00c
`define ASO_CTRL_FMT_BIT  0
`define ASO_CTRL_CES_BIT  1
`define ASO_CTRL_TSS_BIT  2
`define ASO_ST_VALID_BIT  0
`define ASO_ST_INVAL_BIT  1
`define ASO_ST_ICNT_LSB   8
`define ASO_ST_BCNT_LSB   16
`define ASO_CTRL_RST      3'h0
`define ASO_WORD_RST      16'h0000
`define ASO_FRAME_BITS    32
`define ASO_WORD_BITS     16
`define ASO_LAST_BIT      5'h1f
`define ASO_FIRST_PAD     5'h10
`define ASO_INVALID_CONV  7'h7f
`endif

// ===== rtl/aso_pkg.sv
// Purpose: Types shared by the serial output port
// Assumes: Constants come from aso_cfg.svh
// Notes:   Nothing here holds a number of the port
package aso_pkg;
    typedef struct packed {
        logic time_slot_select;
        logic clock_edge_select;
        logic frame_format_select;
    } aso_ctrl_t;

    typedef struct packed {
        logic master_clock;
        logic frame_sync;
        logic line_enable;
    } aso_pins_t;

    typedef enum logic [1:0] {
        ASO_SEL_CTRL,
        ASO_SEL_STATUS,
        ASO_SEL_WORD,
        ASO_SEL_FRAMES
    } aso_sel_t;
endpackage

// ===== rtl/aso_port.sv
// Purpose: Serial output port of a 16-bit converter, clock master of a 3-wire link
// Assumes: clk_i far faster than the master clock pin; pins pass two flip-flops
// Notes:   Conversion words arrive on a valid/ready stream through a small FIFO
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "aso_cfg.svh"
module aso_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_i,       // System clock
    input  wire logic             reset_i,     // Asynchronous reset, high
    input  wire logic             ce_i,        // Clock enable
    input  wire logic [WIDTH-1:0] in_data_i,   // Word to store
    input  wire logic             in_valid_i,  // Word offered
    output logic                  in_ready_o,  // Room for a word
    output logic      [WIDTH-1:0] out_data_o,  // Oldest word
    output logic                  out_valid_o, // Oldest word present
    input  wire logic             out_ready_i  // Oldest word taken
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [CW-1:0]    cnt_q, cnt_d;
    logic             rdy_q, rdy_d, push, pop;
    always_comb begin
        push  = ce_i && in_valid_i && rdy_q;
        pop   = ce_i && out_ready_i && (cnt_q != '0);
        wr_d  = wr_q;
        rd_d  = rd_q;
        cnt_d = cnt_q;
        if (push) begin
            wr_d = (wr_q == PW'(DEPTH - 1)) ? '0 : PW'(wr_q + 1'b1);
        end
        if (pop) begin
            rd_d = (rd_q == PW'(DEPTH - 1)) ? '0 : PW'(rd_q + 1'b1);
        end
        if (push && !pop) begin
            cnt_d = CW'(cnt_q + 1'b1);
        end else if (pop && !push) begin
            cnt_d = CW'(cnt_q - 1'b1);
        end
        rdy_d = (cnt_d != CW'(DEPTH));
    end
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
            rdy_q <= 1'b1;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
            rdy_q <= rdy_d;
        end
    end
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end
    assign in_ready_o  = rdy_q;
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o  = mem_q[rd_q];
endmodule
module aso_port #(
    parameter int WORD_BITS  = `ASO_WORD_BITS,
    parameter int FIFO_DEPTH = 4
) (
    input  wire logic                 clk_i,               // 250 MHz system clock
    input  wire logic                 reset_i,             // Asynchronous reset, high
    input  wire logic                 ce_i,                // Clock enable, freezes all state
    input  wire logic                 psel_i,              // APB select
    input  wire logic                 penable_i,           // APB access phase
    input  wire logic                 pwrite_i,            // APB write
    input  wire logic [11:0]          paddr_i,             // APB byte address
    input  wire logic [31:0]          pwdata_i,            // APB write data
    output logic      [31:0]          prdata_o,            // APB read data
    output logic                      pready_o,            // APB ready
    output logic                      pslverr_o,           // APB error, unmapped address
    input  wire logic [WORD_BITS-1:0] sample_data_i,       // Conversion result
    input  wire logic                 sample_valid_i,      // Result offered
    output logic                      sample_ready_o,      // Result buffer has room
    input  wire logic                 master_clock_in_i,   // Master clock pin
    input  wire logic                 frame_sync_in_i,     // Frame sync input pin
    input  wire logic                 data_line_enable_i,  // Data line enable pin
    output logic                      serial_bit_clock_o,  // Bit clock
    output logic                      frame_sync_out_o,    // Frame sync output
    output logic                      serial_data_out_o,   // Serial data level
    output logic                      serial_data_oe_o,    // Serial data drive enable
    output logic                      result_valid_flag_o  // Result valid flag
);
    aso_pkg::aso_ctrl_t ctrl_q, ctrl_d;
    aso_pkg::aso_pins_t sync1_q, sync2_q, pins_in;
    logic                 mc_prev_q, fsi_smp_q, fsi_smp_d;
    logic                 mc_rise, mc_fall, fsi_rise, valid_rise, launch, resync;
    logic                 sbc_q, sbc_d, fso_q, fso_d, sdo_q, sdo_d, oe_q, oe_d;
    logic [4:0]           bit_cnt_q, bit_cnt_d;
    logic [WORD_BITS-1:0] shift_q, shift_d, word_q, word_d;
    logic [6:0]           inval_q, inval_d;
    logic                 rv_q, rv_d, load;
    logic [15:0]          frames_q, frames_d;
    logic [31:0]          prdata_q, prdata_d;
    logic                 pready_q, pready_d, pslverr_q, pslverr_d;
    logic                 fifo_valid, fifo_ready;
    logic [WORD_BITS-1:0] fifo_data;
    function automatic logic [2:0] reg_decode(input logic [11:0] addr);
        unique case (addr)
            `ASO_CTRL_OFS:   reg_decode = {1'b1, aso_pkg::ASO_SEL_CTRL};
            `ASO_STATUS_OFS: reg_decode = {1'b1, aso_pkg::ASO_SEL_STATUS};
            `ASO_WORD_OFS:   reg_decode = {1'b1, aso_pkg::ASO_SEL_WORD};
            `ASO_FRAMES_OFS: reg_decode = {1'b1, aso_pkg::ASO_SEL_FRAMES};
            default:         reg_decode = 3'h0;
        endcase
    endfunction
    aso_fifo #(
        .WIDTH (WORD_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .reset_i     (reset_i),
        .ce_i        (ce_i),
        .in_data_i   (sample_data_i),
        .in_valid_i  (sample_valid_i),
        .in_ready_o  (fifo_ready),
        .out_data_o  (fifo_data),
        .out_valid_o (fifo_valid),
        .out_ready_i (load)
    );
    // Pins pass two flip-flops; only sync2 is read by logic
    assign pins_in = '{master_clock: master_clock_in_i, frame_sync: frame_sync_in_i,
                       line_enable: data_line_enable_i};
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else if (ce_i) begin
            sync1_q <= pins_in;
            sync2_q <= sync1_q;
        end
    end
    // Link timing: bit clock, frame counter, shift register
    always_comb begin
        mc_rise    = sync2_q.master_clock && !mc_prev_q;
        mc_fall    = !sync2_q.master_clock && mc_prev_q;
        fsi_smp_d  = mc_fall ? sync2_q.frame_sync : fsi_smp_q;
        fsi_rise   = mc_fall && sync2_q.frame_sync && !fsi_smp_q;
        valid_rise = ctrl_q.clock_edge_select ^ ctrl_q.frame_format_select;
        launch     = mc_rise && (sbc_q == valid_rise);
        resync     = fsi_rise && (bit_cnt_q != 5'h00);
        sbc_d      = sbc_q;
        bit_cnt_d  = bit_cnt_q;
        shift_d    = shift_q;
        load       = 1'b0;
        if (resync) begin
            sbc_d     = !valid_rise;
            bit_cnt_d = 5'h00;
            load      = 1'b1;
        end else if (mc_rise) begin
            sbc_d = !sbc_q;
            if (launch) begin
                if (bit_cnt_q == `ASO_LAST_BIT) begin
                    bit_cnt_d = 5'h00;
                    load      = 1'b1;
                end else begin
                    bit_cnt_d = 5'(bit_cnt_q + 1'b1);
                    shift_d   = {shift_q[WORD_BITS-2:0], 1'b0};
                end
            end
        end
        word_d = (load && fifo_valid) ? fifo_data : word_q;
        if (load) begin
            shift_d = word_d;
        end
        inval_d = inval_q;
        if (resync) begin
            inval_d = `ASO_INVALID_CONV;
        end else if (load && (inval_q != 7'h00)) begin
            inval_d = 7'(inval_q - 1'b1);
        end
        rv_d     = rv_q || (load && fifo_valid);
        frames_d = load ? 16'(frames_q + 1'b1) : frames_q;
        sdo_d    = (bit_cnt_d < `ASO_FIRST_PAD) ? shift_d[WORD_BITS-1] : 1'b0;
        if (ctrl_q.frame_format_select) begin
            fso_d = !(bit_cnt_d < `ASO_FIRST_PAD);
        end else begin
            fso_d = (bit_cnt_d == 5'h00);
        end
        oe_d = (sync2_q.line_enable == ctrl_q.time_slot_select);
    end
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            mc_prev_q <= 1'b0;
            fsi_smp_q <= 1'b0;
            sbc_q     <= 1'b0;
            bit_cnt_q <= `ASO_LAST_BIT;
            shift_q   <= `ASO_WORD_RST;
            word_q    <= `ASO_WORD_RST;
            inval_q   <= 7'h00;
            rv_q      <= 1'b0;
            frames_q  <= 16'h0000;
            sdo_q     <= 1'b0;
            fso_q     <= 1'b0;
            oe_q      <= 1'b0;
        end else if (ce_i) begin
            mc_prev_q <= sync2_q.master_clock;
            fsi_smp_q <= fsi_smp_d;
            sbc_q     <= sbc_d;
            bit_cnt_q <= bit_cnt_d;
            shift_q   <= shift_d;
            word_q    <= word_d;
            inval_q   <= inval_d;
            rv_q      <= rv_d;
            frames_q  <= frames_d;
            sdo_q     <= sdo_d;
            fso_q     <= fso_d;
            oe_q      <= oe_d;
        end
    end
    // APB slave: read data and ready prepared in the setup cycle
    always_comb begin
        logic [2:0] sel;
        sel       = reg_decode(paddr_i);
        ctrl_d    = ctrl_q;
        prdata_d  = prdata_q;
        pready_d  = 1'b0;
        pslverr_d = 1'b0;
        if (psel_i && !penable_i) begin
            pready_d  = 1'b1;
            pslverr_d = !sel[2];
            prdata_d  = 32'h0000_0000;
            if (sel[2] && !pwrite_i) begin
                unique case (aso_pkg::aso_sel_t'(sel[1:0]))
                    aso_pkg::ASO_SEL_CTRL: begin
                        prdata_d[`ASO_CTRL_FMT_BIT] = ctrl_q.frame_format_select;
                        prdata_d[`ASO_CTRL_CES_BIT] = ctrl_q.clock_edge_select;
                        prdata_d[`ASO_CTRL_TSS_BIT] = ctrl_q.time_slot_select;
                    end
                    aso_pkg::ASO_SEL_STATUS: begin
                        prdata_d[`ASO_ST_VALID_BIT]                     = rv_q;
                        prdata_d[`ASO_ST_INVAL_BIT]                     = (inval_q != 7'h00);
                        prdata_d[`ASO_ST_ICNT_LSB +: 7]                 = inval_q;
                        prdata_d[`ASO_ST_BCNT_LSB +: 5]                 = bit_cnt_q;
                    end
                    aso_pkg::ASO_SEL_WORD:   prdata_d[WORD_BITS-1:0] = word_q;
                    aso_pkg::ASO_SEL_FRAMES: prdata_d[15:0]          = frames_q;
                endcase
            end
        end
        if (psel_i && penable_i && pready_q && pwrite_i && !pslverr_q &&
            (aso_pkg::aso_sel_t'(sel[1:0]) == aso_pkg::ASO_SEL_CTRL)) begin
            ctrl_d.frame_format_select = pwdata_i[`ASO_CTRL_FMT_BIT];
            ctrl_d.clock_edge_select   = pwdata_i[`ASO_CTRL_CES_BIT];
            ctrl_d.time_slot_select    = pwdata_i[`ASO_CTRL_TSS_BIT];
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ctrl_q    <= `ASO_CTRL_RST;
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else if (ce_i) begin
            ctrl_q    <= ctrl_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign prdata_o            = prdata_q;
    assign pready_o            = pready_q;
    assign pslverr_o           = pslverr_q;
    assign sample_ready_o      = fifo_ready;
    assign serial_bit_clock_o  = sbc_q;
    assign frame_sync_out_o    = fso_q;
    assign serial_data_out_o   = sdo_q;
    assign serial_data_oe_o    = oe_q;
    assign result_valid_flag_o = rv_q;
    sequence s_restart;
        resync && ce_i;
    endsequence
    sequence s_frame_end;
        ce_i && launch && (bit_cnt_q == `ASO_LAST_BIT) && !resync;
    endsequence

    a_line_enable: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i |=> serial_data_oe_o == ($past(sync2_q.line_enable) == $past(ctrl_q.time_slot_select)))
        else $error("data line drive does not follow enable and slot levels");
    a_sync_pulse: assert property (@(posedge clk_i) disable iff (reset_i)
        (ce_i && !ctrl_q.frame_format_select) |=> frame_sync_out_o == ($past(bit_cnt_d) == 5'h00))
        else $error("frame sync pulse not on first bit of frame");
    a_frame_low: assert property (@(posedge clk_i) disable iff (reset_i)
        (ce_i && ctrl_q.frame_format_select) |=> frame_sync_out_o == ($past(bit_cnt_d) >= 5'h10))
        else $error("framed sync not low during data bits");
    a_restart_load: assert property (@(posedge clk_i) disable iff (reset_i)
        s_restart |=> (bit_cnt_q == 5'h00) && (inval_q == 7'h7f))
        else $error("restart did not reload the frame");
    a_valid_kept: assert property (@(posedge clk_i) disable iff (reset_i)
        (rv_q && resync && ce_i) |=> result_valid_flag_o)
        else $error("valid flag dropped at restart");
    a_coincide_keep: assert property (@(posedge clk_i) disable iff (reset_i)
        (ce_i && fsi_rise && bit_cnt_q == 5'h00 && !mc_rise) |=> $stable(bit_cnt_q))
        else $error("aligned frame sync disturbed the frame");
    a_half_clock: assert property (@(posedge clk_i) disable iff (reset_i)
        (ce_i && mc_rise && !resync) |=> serial_bit_clock_o != $past(sbc_q))
        else $error("bit clock did not toggle on master rise");
    a_frame_wrap: assert property (@(posedge clk_i) disable iff (reset_i)
        s_frame_end |=> (bit_cnt_q == 5'h00) && (shift_q == word_q))
        else $error("frame did not wrap after 32 bits");
    a_zero_pad: assert property (@(posedge clk_i) disable iff (reset_i)
        (ce_i && bit_cnt_d >= 5'h10) |=> !serial_data_out_o)
        else $error("pad bit not zero");
    a_msb_first: assert property (@(posedge clk_i) disable iff (reset_i)
        s_frame_end |=> serial_data_out_o == word_q[WORD_BITS-1])
        else $error("first bit is not the most significant");
endmodule

// ===== tb/aso_dsp_model.sv
// Purpose: Far-side receiver, a DSP port framing words on the sync output
// Assumes: Format and edge select levels mirrored by the bench
// Notes:   A released data line shows a level that flips every cycle
`timescale 1ns/1ns
module aso_dsp_model (
    input  wire logic        clk_i,      // System clock
    input  wire logic        reset_i,    // Reset, high
    input  wire logic        bclk_i,     // Bit clock
    input  wire logic        fso_i,      // Frame sync
    input  wire logic        sdo_i,      // Data level
    input  wire logic        oe_i,       // Data drive enable
    input  wire logic        fmt_i,      // Frame format
    input  wire logic        ces_i,      // Clock edge select
    output logic      [15:0] word_o,     // Last word received
    output logic      [15:0] word_cnt_o, // Words received
    output logic             pad_ok_o    // Last frame padded with zeros
);
    logic        bclk_q, fso_q, last_q, pad_q;
    logic [4:0]  idx_q;
    logic [15:0] sh_q;
    logic        line, vedge, start;
    assign line  = oe_i ? sdo_i : ~last_q;
    assign vedge = (bclk_i != bclk_q) && (bclk_i == (ces_i ^ fmt_i));
    assign start = fmt_i ? (fso_q & ~fso_i) : fso_i;
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            bclk_q     <= 1'b0;
            fso_q      <= 1'b0;
            last_q     <= 1'b0;
            pad_q      <= 1'b1;
            idx_q      <= 5'h00;
            sh_q       <= 16'h0000;
            word_o     <= 16'h0000;
            word_cnt_o <= 16'h0000;
            pad_ok_o   <= 1'b0;
        end else begin
            bclk_q <= bclk_i;
            last_q <= line;
            if (vedge) begin
                fso_q <= fso_i;
                if (start || idx_q == 5'h1f) begin
                    idx_q <= 5'h00;
                    sh_q  <= {15'h0000, line};
                    pad_q <= 1'b1;
                end else begin
                    idx_q <= idx_q + 5'h01;
                    sh_q  <= {sh_q[14:0], line};
                    if (idx_q == 5'h0e) begin
                        word_o     <= {sh_q[14:0], line};
                        word_cnt_o <= word_cnt_o + 16'h0001;
                    end
                    if (idx_q > 5'h0e && line)
                        pad_q <= 1'b0;
                    if (idx_q == 5'h1e)
                        pad_ok_o <= pad_q & ~line;
                end
            end
        end
    end
endmodule

// ===== tb/tb.sv
// Purpose: Self-checking bench of the serial output port
// Assumes: Master clock pin of 125 ns, unrelated in phase to the system clock
// Notes:   Random words from a fixed seed, corner cases by hand
`timescale 1ns/1ns
`include "aso_cfg.svh"
`define ASO_CHK(nm, e, g) begin checked++; if ((e) !== (g)) begin error_cnt++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb;
    logic        clk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        psel_i = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0000_0000;
    logic [15:0] sample_data_i = 16'h0000;
    logic        sample_valid_i = 1'b0;
    logic        mclk = 1'b0;
    logic        frame_sync_in = 1'b0;
    logic        de_q = 1'b0;
    logic        tie_fso = 1'b0;
    logic        fmt = 1'b0;
    logic        ces = 1'b0;
    logic [31:0] prdata_o, rd;
    logic        pready_o, pslverr_o, sample_ready_o, bclk, frame_sync_out, serial_data_out, oe, result_valid_flag, er;
    logic [15:0] rx_word, rx_cnt, base;
    logic        rx_pad_ok;
    logic [15:0] w [5];
    int          error_cnt = 0;
    int          checked = 0;
    int          cyc = 0;
    int          hi, lo, n;
    aso_port aso_port_inst (.clk_i(clk_i), .reset_i(reset_i), .ce_i(1'b1), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .sample_data_i(sample_data_i), .sample_valid_i(sample_valid_i),
        .sample_ready_o(sample_ready_o), .master_clock_in_i(mclk), .frame_sync_in_i(frame_sync_in),
        .data_line_enable_i(tie_fso ? frame_sync_out : de_q), .serial_bit_clock_o(bclk),
        .frame_sync_out_o(frame_sync_out), .serial_data_out_o(serial_data_out), .serial_data_oe_o(oe),
        .result_valid_flag_o(result_valid_flag));
    aso_dsp_model aso_dsp_model_inst (.clk_i(clk_i), .reset_i(reset_i), .bclk_i(bclk),
        .fso_i(frame_sync_out), .sdo_i(serial_data_out), .oe_i(oe), .fmt_i(fmt), .ces_i(ces), .word_o(rx_word),
        .word_cnt_o(rx_cnt), .pad_ok_o(rx_pad_ok));
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    initial begin
        #203;
        forever begin
            #62 mclk <= ~mclk;
            #63 mclk <= ~mclk;
        end
    end
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 90000) begin
            error_cnt++;
            results();
        end
    end
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk_i);
        psel_i   <= 1'b1;
        pwrite_i <= wr;
        paddr_i  <= a;
        pwdata_i <= wd;
        @(posedge clk_i);
        penable_i <= 1'b1;
        @(posedge clk_i iff pready_o === 1'b1);
        rd = prdata_o;
        er = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic set_ctrl(input aso_pkg::aso_ctrl_t v);
        apb(1'b1, `ASO_CTRL_OFS, {29'h0000_0000, v});
        fmt <= v.frame_format_select;
        ces <= v.clock_edge_select;
    endtask
    task automatic push(input logic [15:0] d);
        @(posedge clk_i);
        sample_data_i  <= d;
        sample_valid_i <= 1'b1;
        @(posedge clk_i iff sample_ready_o === 1'b1);
        sample_valid_i <= 1'b0;
    endtask
    task automatic wait_words(input int k);
        base = rx_cnt;
        for (n = 0; rx_cnt - base < 16'(k) && n < 3000 * k; n++) @(negedge clk_i);
        if (n >= 3000 * k)
            error_cnt++;
    endtask
    // Times the high and low spans of the bit clock (s high) or the frame sync
    task automatic span(input logic s);
        @(negedge clk_i iff (s ? bclk : frame_sync_out) === 1'b0);
        @(negedge clk_i iff (s ? bclk : frame_sync_out) === 1'b1);
        for (hi = 0; (s ? bclk : frame_sync_out) === 1'b1 && hi < 3000; hi++) @(negedge clk_i);
        for (lo = 0; (s ? bclk : frame_sync_out) === 1'b0 && lo < 3000; lo++) @(negedge clk_i);
    endtask
    // Expected sync shape: one bit clock high, or low through the 16 data bits
    function automatic logic shape_ok(input logic f, input int h, input int l);
        return f ? (l inside {[998:1002]}) : (h inside {[61:64]});
    endfunction
    initial begin
        n = $urandom(44);
        foreach (w[i]) w[i] = 16'($urandom);
        w[0] = 16'h8001;
        repeat (3) @(posedge clk_i);
        reset_i <= 1'b0;
        apb(1'b0, `ASO_CTRL_OFS, 32'h0000_0000);
        `ASO_CHK("ctrl reset", 32'h0000_0000, rd)
        apb(1'b0, `ASO_WORD_OFS, 32'h0000_0000);
        `ASO_CHK("word reset", 32'h0000_0000, rd)
        apb(1'b0, 12'h010, 32'h0000_0000);
        `ASO_CHK("unmapped err", 1'b1, er)
        `ASO_CHK("unmapped data", 32'h0000_0000, rd)
        for (int i = 0; i < 4; i++) push(w[i]);
        @(posedge clk_i);
        @(negedge clk_i);
        `ASO_CHK("fifo full", 1'b0, sample_ready_o)
        for (int i = 0; i < 5; i++) begin
            wait_words(1);
            `ASO_CHK("word order", w[i < 4 ? i : 3], rx_word)
        end
        `ASO_CHK("valid flag", 1'b1, result_valid_flag)
        apb(1'b0, `ASO_WORD_OFS, 32'h0000_0000);
        `ASO_CHK("word reg", {16'h0000, w[3]}, rd)
        apb(1'b0, `ASO_FRAMES_OFS, 32'h0000_0000);
        hi = rd[15:0];
        wait_words(1);
        apb(1'b0, `ASO_FRAMES_OFS, 32'h0000_0000);
        `ASO_CHK("frame count", 16'(hi + 1), rd[15:0])
        span(1'b1);
        `ASO_CHK("bit clock", 1'b1, (hi + lo) inside {[61:64]})
        for (int m = 0; m < 4; m++) begin
            set_ctrl(3'(m));
            apb(1'b0, `ASO_CTRL_OFS, 32'h0000_0000);
            `ASO_CHK("ctrl rw", 32'(m), rd)
            w[4] = 16'($urandom);
            push(w[4]);
            wait_words(2);
            `ASO_CHK("mode word", w[4], rx_word)
            `ASO_CHK("zero pad", 1'b1, rx_pad_ok)
            span(1'b0);
            `ASO_CHK("sync shape", 1'b1, shape_ok(m[0], hi, lo))
            `ASO_CHK("frame length", 1'b1, (hi + lo) inside {[1998:2002]})
        end
        set_ctrl(3'h0);
        wait_words(1);
        repeat (100 + $urandom % 600) @(posedge clk_i);
        w[4] = 16'($urandom);
        push(w[4]);
        frame_sync_in <= 1'b1;
        repeat (50) @(posedge clk_i);
        apb(1'b0, `ASO_STATUS_OFS, 32'h0000_0000);
        `ASO_CHK("invalid pending", 1'b1, rd[`ASO_ST_INVAL_BIT])
        `ASO_CHK("invalid count", `ASO_INVALID_CONV, rd[14:8])
        `ASO_CHK("restart bit", 1'b1, rd[20:16] < 5'h02)
        `ASO_CHK("valid kept", 1'b1, result_valid_flag)
        wait_words(1);
        `ASO_CHK("restart word", w[4], rx_word)
        span(1'b0);
        `ASO_CHK("steady input frame", 1'b1, (hi + lo) inside {[1998:2002]})
        apb(1'b0, `ASO_STATUS_OFS, 32'h0000_0000);
        `ASO_CHK("invalid counts down", 1'b1, rd[14:8] < `ASO_INVALID_CONV)
        frame_sync_in <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            set_ctrl({i[1], 2'b00});
            de_q <= i[0];
            repeat (8) @(posedge clk_i);
            `ASO_CHK("drive enable", (i[0] == i[1]), oe)
        end
        @(posedge clk_i iff frame_sync_out === 1'b0);
        @(posedge clk_i iff frame_sync_out === 1'b1);
        frame_sync_in <= 1'b1;
        repeat (100) @(posedge clk_i);
        apb(1'b0, `ASO_STATUS_OFS, 32'h0000_0000);
        `ASO_CHK("aligned sync ignored", 1'b1, rd[14:8] < `ASO_INVALID_CONV)
        tie_fso <= 1'b1;
        @(negedge clk_i iff frame_sync_out === 1'b1);
        repeat (8) @(negedge clk_i);
        `ASO_CHK("enable from sync high", 1'b1, oe)
        @(negedge clk_i iff frame_sync_out === 1'b0);
        repeat (8) @(negedge clk_i);
        `ASO_CHK("enable from sync low", 1'b0, oe)
        results();
    end
endmodule
